// file: hdl/iec_pkg.sv
// constants, register map and state encoding of the two-wire bus event and call logic
`default_nettype none
package iec_pkg;
	// register byte addresses on the 32-bit register bus
	localparam logic [7:0] REG_OWN_ADDR = 8'h00;
	localparam logic [7:0] REG_RATE = 8'h04;
	localparam logic [7:0] REG_CTRL = 8'h08;
	localparam logic [7:0] REG_STATUS = 8'h0C;
	localparam logic [7:0] REG_DATA = 8'h10;
	localparam logic [7:0] REG_CFG = 8'h14;
	localparam logic [7:0] REG_RESET_VAL = 8'h00;
	// main_control fields
	localparam int CTL_EN = 7;
	localparam int CTL_IE = 6;
	localparam int CTL_MST = 5;
	localparam int CTL_TX = 4;
	localparam int CTL_ACK_SUPPRESS_BIT = 3;
	localparam int CTL_REPEAT_START_REQUEST = 2;
	// event_status fields
	localparam int ST_TCF = 7;
	localparam int ST_ADDRESSED_AS_SLAVE_FLAG = 6;
	localparam int ST_BUSY = 5;
	localparam int ST_LOST_ARBITRATION_FLAG = 4;
	localparam int ST_SRW = 2;
	localparam int ST_IIF = 1;
	localparam int ST_ACK_RECEIVED_FLAG = 0;
	// address_config fields
	localparam int CFG_GCEN = 7;
	localparam int CFG_EXT = 6;
	// bus framing
	localparam logic [7:0] GEN_CALL_ADDR = 8'h00;
	localparam logic [3:0] BIT_ACK = 4'h8;
	localparam logic [3:0] BIT_LAST_DATA = 4'h7;
	// scl divider: base count plus two per rate code step
	localparam logic [15:0] SCL_DIV_BASE = 16'h0014;
	typedef enum logic [2:0] {
		M_IDLE = 3'b000,
		M_START = 3'b001,
		M_WAIT = 3'b010,
		M_LOW = 3'b011,
		M_HIGH = 3'b100,
		M_STOP = 3'b101,
		M_RSTART = 3'b110
	} iec_mstate_e;
endpackage
`default_nettype wire

// file: hdl/iec_top.sv
// two-wire bus controller: registers, bus monitor, master sequencer, events and interrupt
//
// Decided for this implementation: the register offsets and register access over Wishbone.
`default_nettype none
// Operation
// - with general call enabled, answer address 00 as well as own address
// - a general call makes us slave receiver; addressed flag set after address cycle
// - after first byte the data register holds the address byte; 00 means general call
// - general call disabled: no acknowledge, following data ignored
// - disabled after reset; never requests a system reset
// - one interrupt output: pending flag gated by interrupt enable
// - pending flag cleared only by writing 1; writing 0 leaves it
// - byte done, address match and lost arbitration set pending and their own flag
// - byte done flag set on falling edge of ninth serial clock
// - addressed flag on own address match or enabled general call
// - losing arbitration sets lost flag and raises the interrupt event
// - lost when driving sda high but sampling low in transmit bits or receive ack
// - lost when a start is attempted while the bus is busy
// - lost when a repeated start is requested in slave mode
// - lost when a stop appears that the master did not request
// - lost flag cleared only by writing 1
// - scl rate is bus clock over two, multiplier and divider
// - status bits: done, addressed, busy, lost, 0, direction, pending, ack
// - control bits: enable, irq enable, master, transmit, ack suppress, rstart, 0, 0
// - config bits: general call enable, extended, three zeros, address bits 10..8
// - own address bits 7..1 in upper bits, bit 0 reads zero
module iec_top (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	output logic [31:0] dat_o,
	output logic ack_o,
	input wire logic scl_i,
	output logic scl_o,
	output logic scl_oe_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe_o,
	output logic irq_o
);

	////////////////////////////////////////////////////////////////////////////
	// registers and engine state
	logic [7:1] own_slave_address;
	logic [7:0] rate_divider_setting;
	logic module_enable_bit;
	logic irq_enable_bit;
	logic controller_select;
	logic tx_select;
	logic ack_suppress_bit;
	logic general_call_enable;
	logic extended_address_select;
	logic [2:0] upper_slave_address;
	logic byte_done_flag;
	logic addressed_as_slave_flag;
	logic bus_busy;
	logic lost_arbitration_flag;
	logic slave_direction_flag;
	logic irq_pending_flag;
	logic ack_received_flag;
	logic [7:0] bus_byte_buffer;
	logic scl_q;
	logic sda_q;
	logic [3:0] bit_cnt;
	logic [7:0] shreg;
	logic addr_phase;
	logic hold;
	logic data_sda;
	logic m_scl;
	logic m_sda;
	logic stop_req;
	logic [1:0] phase;
	logic [15:0] cnt;
	iec_pkg::iec_mstate_e mstate;
	logic [7:0] rdata;

	// half scl period in clock cycles: multiplier times divider
	function automatic logic [15:0] half_period(input logic [7:0] rate);
		logic [15:0] div;
		div = iec_pkg::SCL_DIV_BASE + {9'h000, rate[5:0], 1'b0};
		case (rate[7:6])
			2'b01: return {div[14:0], 1'b0};
			2'b10: return {div[13:0], 2'b00};
			default: return div;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// register bus decode
	logic acc;
	logic wr;
	logic wr_ctl;
	logic wr_stat;
	logic wr_data;
	logic rd_data;
	assign acc = cyc_i & stb_i & ack_o;
	assign wr = acc & we_i & sel_i[0];
	assign wr_ctl = wr & (adr_i == iec_pkg::REG_CTRL);
	assign wr_stat = wr & (adr_i == iec_pkg::REG_STATUS);
	assign wr_data = wr & (adr_i == iec_pkg::REG_DATA);
	assign rd_data = acc & !we_i & (adr_i == iec_pkg::REG_DATA);

	////////////////////////////////////////////////////////////////////////////
	// bus monitor and event decode
	logic en;
	logic rise;
	logic fall;
	logic start_ev;
	logic stop_ev;
	logic hit;
	logic xmit;
	logic part;
	logic ninth_fall;
	logic ninth_part;
	logic addr_set;
	logic cmd_start;
	logic cmd_repeat_start_request;
	logic arb_ev;
	logic tick;
	logic [15:0] half;
	assign en = module_enable_bit;
	assign rise = scl_i & !scl_q;
	assign fall = !scl_i & scl_q;
	assign start_ev = en & scl_i & scl_q & sda_q & !sda_i;
	assign stop_ev = en & scl_i & scl_q & !sda_q & sda_i;
	assign hit = (shreg[7:1] == own_slave_address)
		| (general_call_enable & (shreg == iec_pkg::GEN_CALL_ADDR));
	assign xmit = controller_select ? (addr_phase | tx_select)
		: (addressed_as_slave_flag & tx_select & !addr_phase);
	assign part = controller_select | addressed_as_slave_flag;
	assign ninth_fall = en & bus_busy & fall & (bit_cnt == iec_pkg::BIT_ACK);
	assign addr_set = ninth_fall & addr_phase & hit & !controller_select;
	assign ninth_part = part | addr_set;
	assign cmd_start = en & wr_ctl & dat_i[iec_pkg::CTL_MST] & !controller_select;
	assign cmd_repeat_start_request = en & wr_ctl & dat_i[iec_pkg::CTL_REPEAT_START_REQUEST];
	assign arb_ev = (en & controller_select & rise & xmit & (bit_cnt <= iec_pkg::BIT_LAST_DATA)
			& shreg[7] & !sda_i)
		| (en & controller_select & rise & !xmit & !addr_phase & (bit_cnt == iec_pkg::BIT_ACK)
			& ack_suppress_bit & !sda_i)
		| (cmd_start & bus_busy)
		| (cmd_repeat_start_request & !controller_select)
		| (stop_ev & controller_select & !stop_req);
	assign tick = (cnt == 16'h0000);
	assign half = half_period(rate_divider_setting);

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scl_q <= 1'b1;
			sda_q <= 1'b1;
		end else begin
			scl_q <= scl_i;
			sda_q <= sda_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !en || stop_ev) begin
			bus_busy <= 1'b0;
		end else if (start_ev) begin
			bus_busy <= 1'b1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !en || stop_ev) begin
			bit_cnt <= 4'h0;
		end else if (start_ev) begin
			// wraps to zero on the fall that ends the start, so that fall is no data bit
			bit_cnt <= 4'hF;
		end else if (fall && bus_busy) begin
			bit_cnt <= (bit_cnt == iec_pkg::BIT_ACK) ? 4'h0 : bit_cnt + 4'h1;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !en || stop_ev || ninth_fall) begin
			addr_phase <= 1'b0;
		end else if (start_ev) begin
			addr_phase <= 1'b1;
		end
	end

	// shift register carries both the byte being sent and the byte seen on the wire
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			shreg <= iec_pkg::REG_RESET_VAL;
		end else if (wr_data && hold) begin
			shreg <= dat_i[7:0];
		end else if (rise && bus_busy && bit_cnt <= iec_pkg::BIT_LAST_DATA) begin
			shreg <= {shreg[6:0], sda_i};
		end
	end

	// sda data drive changes only while scl is low
	always_ff @(posedge clk_i) begin
		if (rst_i || !en || start_ev || stop_ev || arb_ev) begin
			data_sda <= 1'b0;
		end else if (wr_data && hold) begin
			data_sda <= xmit & !dat_i[7];
		end else if (fall && bus_busy) begin
			if (bit_cnt == iec_pkg::BIT_ACK) begin
				data_sda <= 1'b0;
			end else if (bit_cnt == iec_pkg::BIT_LAST_DATA) begin
				if (xmit) begin
					data_sda <= 1'b0;
				end else if (addr_phase) begin
					data_sda <= !controller_select & hit;
				end else begin
					data_sda <= part & !ack_suppress_bit;
				end
			end else begin
				data_sda <= xmit & !shreg[7];
			end
		end
	end

	// clock stretch after each byte until software touches the data register
	always_ff @(posedge clk_i) begin
		if (rst_i || !en || stop_ev || arb_ev) begin
			hold <= 1'b0;
		end else if (ninth_fall && ninth_part) begin
			hold <= 1'b1;
		end else if (tick && (mstate == iec_pkg::M_START || (mstate == iec_pkg::M_RSTART && phase == 2'd2))) begin
			hold <= 1'b1;
		end else if (wr_data || rd_data) begin
			hold <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// master sequencer
	always_ff @(posedge clk_i) begin
		if (rst_i || !en || arb_ev) begin
			mstate <= iec_pkg::M_IDLE;
			m_scl <= 1'b0;
			m_sda <= 1'b0;
			phase <= 2'd0;
			cnt <= 16'h0000;
			stop_req <= 1'b0;
		end else begin
			if (!tick) begin
				cnt <= cnt - 16'h0001;
			end
			unique case (mstate)
				iec_pkg::M_IDLE: begin
					stop_req <= 1'b0;
					if (cmd_start) begin
						m_sda <= 1'b1;
						cnt <= half;
						mstate <= iec_pkg::M_START;
					end
				end
				iec_pkg::M_START: begin
					if (tick) begin
						m_scl <= 1'b1;
						mstate <= iec_pkg::M_WAIT;
					end
				end
				iec_pkg::M_WAIT: begin
					phase <= 2'd0;
					cnt <= half;
					if (wr_ctl && !dat_i[iec_pkg::CTL_MST]) begin
						m_sda <= 1'b1;
						stop_req <= 1'b1;
						mstate <= iec_pkg::M_STOP;
					end else if (cmd_repeat_start_request) begin
						m_sda <= 1'b0;
						mstate <= iec_pkg::M_RSTART;
					end else if (wr_data || rd_data) begin
						m_sda <= 1'b0;
						mstate <= iec_pkg::M_LOW;
					end
				end
				iec_pkg::M_LOW: begin
					if (tick) begin
						m_scl <= 1'b0;
						cnt <= half;
						mstate <= iec_pkg::M_HIGH;
					end
				end
				iec_pkg::M_HIGH: begin
					// slaves may stretch: high time counts only once scl is seen high
					if (!scl_i) begin
						cnt <= half;
					end else if (tick) begin
						m_scl <= 1'b1;
						cnt <= half;
						mstate <= (bit_cnt == iec_pkg::BIT_ACK) ? iec_pkg::M_WAIT : iec_pkg::M_LOW;
					end
				end
				iec_pkg::M_STOP: begin
					if (phase == 2'd0 && tick) begin
						m_scl <= 1'b0;
						cnt <= half;
						phase <= 2'd1;
					end else if (phase == 2'd1 && !scl_i) begin
						cnt <= half;
					end else if (phase == 2'd1 && tick) begin
						m_sda <= 1'b0;
						mstate <= iec_pkg::M_IDLE;
					end
				end
				iec_pkg::M_RSTART: begin
					if (phase == 2'd0 && tick) begin
						m_scl <= 1'b0;
						cnt <= half;
						phase <= 2'd1;
					end else if (phase == 2'd1 && !scl_i) begin
						cnt <= half;
					end else if (phase == 2'd1 && tick) begin
						m_sda <= 1'b1;
						cnt <= half;
						phase <= 2'd2;
					end else if (phase == 2'd2 && tick) begin
						m_scl <= 1'b1;
						mstate <= iec_pkg::M_WAIT;
					end
				end
				default: begin
					mstate <= iec_pkg::M_IDLE;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// software registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			own_slave_address <= 7'h00;
			rate_divider_setting <= iec_pkg::REG_RESET_VAL;
			general_call_enable <= 1'b0;
			extended_address_select <= 1'b0;
			upper_slave_address <= 3'h0;
		end else begin
			if (wr && adr_i == iec_pkg::REG_OWN_ADDR) begin
				own_slave_address <= dat_i[7:1];
			end
			if (wr && adr_i == iec_pkg::REG_RATE) begin
				rate_divider_setting <= dat_i[7:0];
			end
			if (wr && adr_i == iec_pkg::REG_CFG) begin
				general_call_enable <= dat_i[iec_pkg::CFG_GCEN];
				extended_address_select <= dat_i[iec_pkg::CFG_EXT];
				upper_slave_address <= dat_i[2:0];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			module_enable_bit <= 1'b0;
			irq_enable_bit <= 1'b0;
			tx_select <= 1'b0;
			ack_suppress_bit <= 1'b0;
		end else if (wr_ctl) begin
			module_enable_bit <= dat_i[iec_pkg::CTL_EN];
			irq_enable_bit <= dat_i[iec_pkg::CTL_IE];
			tx_select <= dat_i[iec_pkg::CTL_TX];
			ack_suppress_bit <= dat_i[iec_pkg::CTL_ACK_SUPPRESS_BIT];
		end
	end

	// hardware clear on lost arbitration must not be taken as a stop command
	always_ff @(posedge clk_i) begin
		if (rst_i || !en || arb_ev) begin
			controller_select <= 1'b0;
		end else if (wr_ctl) begin
			controller_select <= dat_i[iec_pkg::CTL_MST];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// event flags: a set in the same cycle as a clear wins
	always_ff @(posedge clk_i) begin
		if (rst_i || !en) begin
			byte_done_flag <= 1'b0;
		end else if (ninth_fall && ninth_part) begin
			byte_done_flag <= 1'b1;
		end else if (wr_data || rd_data) begin
			byte_done_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !en) begin
			addressed_as_slave_flag <= 1'b0;
			slave_direction_flag <= 1'b0;
		end else if (addr_set) begin
			addressed_as_slave_flag <= 1'b1;
			slave_direction_flag <= shreg[0];
		end else if (start_ev || stop_ev || wr_ctl) begin
			addressed_as_slave_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			lost_arbitration_flag <= 1'b0;
		end else if (arb_ev) begin
			lost_arbitration_flag <= 1'b1;
		end else if (wr_stat && dat_i[iec_pkg::ST_LOST_ARBITRATION_FLAG]) begin
			lost_arbitration_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			irq_pending_flag <= 1'b0;
		end else if ((ninth_fall && ninth_part) || arb_ev) begin
			irq_pending_flag <= 1'b1;
		end else if (wr_stat && dat_i[iec_pkg::ST_IIF]) begin
			irq_pending_flag <= 1'b0;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i || !en) begin
			ack_received_flag <= 1'b0;
		end else if (rise && bus_busy && xmit && bit_cnt == iec_pkg::BIT_ACK) begin
			ack_received_flag <= sda_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			bus_byte_buffer <= iec_pkg::REG_RESET_VAL;
		end else if (ninth_fall && ninth_part) begin
			bus_byte_buffer <= shreg;
		end else if (wr_data) begin
			bus_byte_buffer <= dat_i[7:0];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read mux, bus answer and pins
	always_comb begin
		rdata = iec_pkg::REG_RESET_VAL;
		case (adr_i)
			iec_pkg::REG_OWN_ADDR: rdata = {own_slave_address, 1'b0};
			iec_pkg::REG_RATE: rdata = rate_divider_setting;
			iec_pkg::REG_CTRL: rdata = {module_enable_bit, irq_enable_bit, controller_select, tx_select,
				ack_suppress_bit, 3'b000};
			iec_pkg::REG_STATUS: rdata = {byte_done_flag, addressed_as_slave_flag, bus_busy,
				lost_arbitration_flag, 1'b0, slave_direction_flag, irq_pending_flag, ack_received_flag};
			iec_pkg::REG_DATA: rdata = bus_byte_buffer;
			iec_pkg::REG_CFG: rdata = {general_call_enable, extended_address_select, 3'b000,
				upper_slave_address};
			default: rdata = iec_pkg::REG_RESET_VAL;
		endcase
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_o <= 1'b0;
			dat_o <= 32'h0000_0000;
		end else begin
			ack_o <= cyc_i & stb_i & !ack_o;
			if (cyc_i && stb_i && !ack_o) begin
				dat_o <= {24'h00_0000, rdata};
			end
		end
	end

	// open drain: outputs stay low, enables pull the wire
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			scl_o <= 1'b0;
			sda_o <= 1'b0;
			scl_oe_o <= 1'b0;
			sda_oe_o <= 1'b0;
			irq_o <= 1'b0;
		end else begin
			scl_o <= 1'b0;
			sda_o <= 1'b0;
			scl_oe_o <= en & (m_scl | (hold & !controller_select));
			sda_oe_o <= en & (m_sda | data_sda);
			irq_o <= irq_pending_flag & irq_enable_bit;
		end
	end

endmodule
`default_nettype wire

// file: tb/iec_checker.sv
// concurrent checks on register bus, interrupt and pin drive of the bus controller
`default_nettype none
module iec_checker (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic cyc_i,
	input wire logic stb_i,
	input wire logic we_i,
	input wire logic [3:0] sel_i,
	input wire logic [7:0] adr_i,
	input wire logic [31:0] dat_i,
	input wire logic [31:0] dat_o,
	input wire logic ack_o,
	input wire logic scl_oe_o,
	input wire logic sda_oe_o,
	input wire logic irq_o
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	logic en_sh;
	logic ie_sh;
	logic [2:0] clr_h;
	logic wr_ack;
	logic rd_ack;
	assign wr_ack = ack_o && cyc_i && stb_i && we_i && sel_i[0];
	assign rd_ack = ack_o && cyc_i && stb_i && !we_i;
	////////////////////////////////////////////////////////////////
	// shadow of enable bits, since the flags themselves are not visible here
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_sh <= 1'b0;
			ie_sh <= 1'b0;
		end else if (wr_ack && adr_i == iec_pkg::REG_CTRL) begin
			en_sh <= dat_i[iec_pkg::CTL_EN];
			ie_sh <= dat_i[iec_pkg::CTL_IE];
		end
	end
	// history of writes that may lower the interrupt; irq lags the flags
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			clr_h <= 3'b000;
		end else begin
			clr_h <= {clr_h[1:0], wr_ack && ((adr_i == iec_pkg::REG_STATUS && dat_i[1])
				|| (adr_i == iec_pkg::REG_CTRL && !dat_i[6]))};
		end
	end
	////////////////////////////////////////////////////////////////
	sequence s_req;
		cyc_i && stb_i && !ack_o;
	endsequence
	sequence s_pulse;
		ack_o ##1 !ack_o;
	endsequence
	a_ack_one_pulse: assert property (s_req |=> s_pulse)
		else $error("ack not a single pulse one cycle after request");
	a_reset_quiet: assert property (disable iff (1'b0) rst_i |=> !irq_o && !ack_o && !sda_oe_o && !scl_oe_o)
		else $error("outputs active after reset");
	a_off_no_drive: assert property (!en_sh && !$past(en_sh) |-> !sda_oe_o && !scl_oe_o)
		else $error("pins driven while disabled");
	a_irq_masked: assert property (!ie_sh && !$past(ie_sh) |-> !irq_o)
		else $error("irq high with interrupt enable clear");
	a_irq_clear_cause: assert property ($fell(irq_o) |-> clr_h != 3'b000 || $past(rst_i))
		else $error("irq fell without a clearing write");
	a_unmapped_zero: assert property (rd_ack && adr_i > 8'h14 |-> dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_own_lsb_zero: assert property (rd_ack && adr_i == iec_pkg::REG_OWN_ADDR |-> dat_o[0] == 1'b0)
		else $error("own address bit 0 not zero");
	a_ctrl_low_zero: assert property (rd_ack && adr_i == iec_pkg::REG_CTRL |-> dat_o[2:0] == 3'b000)
		else $error("control low bits not zero");
	a_cfg_mid_zero: assert property (rd_ack && adr_i == iec_pkg::REG_CFG |-> dat_o[5:3] == 3'b000)
		else $error("config bits 5 to 3 not zero");
	a_status_gap_zero: assert property (rd_ack && adr_i == iec_pkg::REG_STATUS |-> dat_o[3] == 1'b0)
		else $error("status bit 3 not zero");
endmodule
bind iec_top iec_checker u_iec_checker (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
	.we_i(we_i), .sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
	.scl_oe_o(scl_oe_o), .sda_oe_o(sda_oe_o), .irq_o(irq_o));
`default_nettype wire

// file: tb/iec_bus_model.sv
// behavioural second bus party: another master on the wires, plus the pull-ups
`default_nettype none
module iec_bus_model (
	input wire logic clk_i,
	input wire logic scl_oe_i,
	input wire logic sda_oe_i,
	output logic scl_o,
	output logic sda_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic m_scl = 1'b1;
	logic m_sda = 1'b1;
	// pull-ups on both wires: whoever pulls low wins
	assign scl_o = !(scl_oe_i || !m_scl);
	assign sda_o = !(sda_oe_i || !m_sda);
	task automatic tick(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	// release clock, then wait out any stretch by the device
	task automatic scl_up(input int h);
		int w;
		w = 0;
		m_scl <= 1'b1;
		do begin
			@(posedge clk_i);
			w++;
		end while (scl_o !== 1'b1 && w < 20000);
		tick(h);
	endtask
	task automatic start(input int h);
		m_sda <= 1'b0;
		tick(h);
		m_scl <= 1'b0;
		tick(h);
	endtask
	// msb first; data moves a few clocks after the fall so no false start or stop is seen
	task automatic send(input logic [7:0] b, input int h, output logic ack);
		for (int i = 7; i >= 0; i--) begin
			m_sda <= b[i];
			tick(h);
			scl_up(h);
			m_scl <= 1'b0;
			tick(4);
		end
		m_sda <= 1'b1;
		tick(h);
		scl_up(h);
		ack = sda_o;
		m_scl <= 1'b0;
		tick(4);
	endtask
	task automatic stop(input int h);
		m_sda <= 1'b0;
		tick(h);
		scl_up(h);
		m_sda <= 1'b1;
		tick(h);
	endtask
	// holds data low under a transmitting device to win arbitration against it
	task automatic jam(input int h);
		int w;
		w = 0;
		while (!(sda_o === 1'b0 && scl_o === 1'b1) && w < 20000) begin
			tick(1);
			w++;
		end
		while (scl_o !== 1'b0 && w < 20000) begin
			tick(1);
			w++;
		end
		m_sda <= 1'b0;
		tick(8 * h);
		m_sda <= 1'b1;
		tick(h);
	endtask
endmodule
`default_nettype wire

// file: tb/iec_top_tb_top.sv
// self-checking bench: register map, address events, general call, arbitration loss, rate
`default_nettype none
module iec_top_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc_i = 1'b0;
	logic stb_i = 1'b0;
	logic we_i = 1'b0;
	logic [3:0] sel_i = 4'h0;
	logic [7:0] adr_i = 8'h00;
	logic [31:0] dat_i = 32'h0000_0000;
	logic [31:0] dat_o;
	logic ack_o;
	logic scl_oe_o;
	logic sda_oe_o;
	logic irq_o;
	logic scl_o;
	logic sda_o;
	logic sel0 = 1'b1;
	wire logic scl_w;
	wire logic sda_w;
	logic [15:0] notes[$];
	logic [15:0] nt;
	int n_errors = 0;
	int cmp_count = 0;
	always #25 clk_i = ~clk_i;
	iec_top u_iec_top (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i),
		.sel_i(sel_i), .adr_i(adr_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o), .scl_i(scl_w),
		.scl_o(scl_o), .scl_oe_o(scl_oe_o), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_o(sda_oe_o), .irq_o(irq_o));
	iec_bus_model u_iec_bus_model (.clk_i(clk_i), .scl_oe_i(scl_oe_o), .sda_oe_i(sda_oe_o),
		.scl_o(scl_w), .sda_o(sda_w));
	////////////////////////////////////////////////////////////////
	task automatic cmp_reg(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m, input logic [7:0] s);
		cmp_count++;
		if ((s & m) !== (e & m)) begin
			n_errors++;
			$display("mismatch reg_%h expected %h seen %h", a, e & m, s & m);
		end
	endtask
	task automatic chk_rng(input string nm, input int lo, input int hi, input logic [15:0] s);
		cmp_count++;
		if ((s >= lo && s <= hi) !== 1'b1) begin
			n_errors++;
			$display("mismatch %s expected %0d..%0d seen %0d", nm, lo, hi, s);
		end
	endtask
	// single classic cycle; a read notes its expectation for the monitor
	task automatic wb(input logic w, input logic [7:0] a, input logic [7:0] d, input logic [7:0] e,
		input logic [7:0] m);
		int t;
		@(posedge clk_i);
		cyc_i <= 1'b1;
		stb_i <= 1'b1;
		we_i <= w;
		adr_i <= a;
		dat_i <= {24'($urandom()), d};
		sel_i <= {3'($urandom()), sel0};
		if (!w) notes.push_back({e, m});
		t = 0;
		do begin
			@(posedge clk_i);
			t++;
		end while (ack_o !== 1'b1 && t < 50);
		cyc_i <= 1'b0;
		stb_i <= 1'b0;
		we_i <= 1'b0;
		chk_rng("wb_ack", 1, 49, t[15:0]);
	endtask
	task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		wb(1'b0, a, 8'h00, e, m);
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		wb(1'b1, a, d, 8'h00, 8'h00);
	endtask
	task automatic wait_irq(input logic e);
		int t;
		t = 0;
		while (irq_o !== e && t < 3000) begin
			@(posedge clk_i);
			t++;
		end
		chk_rng("irq_o", e, e, {15'h0000, irq_o});
	endtask
	task automatic wrap_up();
		$display("comparisons %0d errors %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	always @(posedge clk_i) begin
		if (ack_o === 1'b1 && we_i === 1'b0 && notes.size() > 0) begin
			nt = notes.pop_front();
			cmp_reg(adr_i, nt[15:8], nt[7:0], dat_o[7:0]);
		end
	end
	initial begin
		repeat (60000) @(posedge clk_i);
		n_errors++;
		$display("mismatch watchdog expected done seen timeout");
		wrap_up();
	end
	initial begin
		int p;
		int mc;
		int code;
		int hf;
		logic ak;
		logic [6:0] a;
		time t0;
		p = $urandom(32'h484c1536);
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			rd(8'(i * 4), 8'h00, 8'hFF);
		end
		wr(iec_pkg::REG_OWN_ADDR, 8'hFF);
		rd(iec_pkg::REG_OWN_ADDR, 8'hFE, 8'hFF);
		// a write without the low byte lane must leave the register alone
		sel0 = 1'b0;
		wr(iec_pkg::REG_OWN_ADDR, 8'h00);
		sel0 = 1'b1;
		rd(iec_pkg::REG_OWN_ADDR, 8'hFE, 8'hFF);
		wr(iec_pkg::REG_CTRL, 8'h5F);
		rd(iec_pkg::REG_CTRL, 8'h58, 8'hFF);
		wr(iec_pkg::REG_CFG, 8'hFF);
		rd(iec_pkg::REG_CFG, 8'hC7, 8'hFF);
		wr(8'h18, 8'hFF);
		rd(8'h18, 8'h00, 8'hFF);
		rd(iec_pkg::REG_STATUS, 8'h00, 8'hFF);
		wr(iec_pkg::REG_CFG, 8'h00);
		// own address match as slave receiver
		a = 7'($urandom_range(8, 119));
		wr(iec_pkg::REG_OWN_ADDR, {a, 1'b0});
		wr(iec_pkg::REG_CTRL, 8'hC0);
		u_iec_bus_model.start(25);
		u_iec_bus_model.send({a, 1'b0}, 25, ak);
		chk_rng("slave_ack", 0, 0, {15'h0000, ak});
		wait_irq(1'b1);
		rd(iec_pkg::REG_STATUS, 8'hE2, 8'hFE);
		wr(iec_pkg::REG_CTRL, 8'hC0);
		rd(iec_pkg::REG_DATA, {a, 1'b0}, 8'hFF);
		wr(iec_pkg::REG_STATUS, 8'h00);
		rd(iec_pkg::REG_STATUS, 8'h02, 8'h02);
		wr(iec_pkg::REG_STATUS, 8'h02);
		rd(iec_pkg::REG_STATUS, 8'h00, 8'h02);
		wait_irq(1'b0);
		u_iec_bus_model.stop(25);
		// general call, enabled, slow far side
		wr(iec_pkg::REG_CFG, 8'h80);
		u_iec_bus_model.start(60);
		u_iec_bus_model.send(iec_pkg::GEN_CALL_ADDR, 60, ak);
		chk_rng("gc_ack", 0, 0, {15'h0000, ak});
		wait_irq(1'b1);
		rd(iec_pkg::REG_STATUS, 8'hE2, 8'hFE);
		rd(iec_pkg::REG_DATA, 8'h00, 8'hFF);
		wr(iec_pkg::REG_STATUS, 8'h02);
		u_iec_bus_model.stop(60);
		// general call, disabled: address and data both ignored
		wr(iec_pkg::REG_CFG, 8'h00);
		u_iec_bus_model.start(25);
		u_iec_bus_model.send(iec_pkg::GEN_CALL_ADDR, 25, ak);
		chk_rng("gc_off_ack", 1, 1, {15'h0000, ak});
		u_iec_bus_model.send(8'h55, 25, ak);
		chk_rng("gc_off_data_ack", 1, 1, {15'h0000, ak});
		u_iec_bus_model.stop(25);
		rd(iec_pkg::REG_STATUS, 8'h00, 8'hC2);
		// start attempted on a busy bus, interrupt masked
		wr(iec_pkg::REG_CTRL, 8'h80);
		u_iec_bus_model.start(25);
		wr(iec_pkg::REG_CTRL, 8'hA0);
		rd(iec_pkg::REG_STATUS, 8'h12, 8'h12);
		rd(iec_pkg::REG_CTRL, 8'h80, 8'hE0);
		chk_rng("irq_masked", 0, 0, {15'h0000, irq_o});
		wr(iec_pkg::REG_STATUS, 8'h00);
		rd(iec_pkg::REG_STATUS, 8'h12, 8'h12);
		wr(iec_pkg::REG_STATUS, 8'h12);
		rd(iec_pkg::REG_STATUS, 8'h00, 8'h12);
		u_iec_bus_model.stop(25);
		// repeated start requested in slave mode
		wr(iec_pkg::REG_CTRL, 8'h84);
		rd(iec_pkg::REG_STATUS, 8'h12, 8'h12);
		wr(iec_pkg::REG_STATUS, 8'h12);
		// data line pulled low under our high address bit
		wr(iec_pkg::REG_CTRL, 8'hC0);
		fork
			u_iec_bus_model.jam(25);
			begin
				wr(iec_pkg::REG_CTRL, 8'hF0);
				@(negedge scl_w);
				wr(iec_pkg::REG_DATA, 8'hFF);
				wait_irq(1'b1);
			end
		join
		rd(iec_pkg::REG_STATUS, 8'h12, 8'h12);
		wr(iec_pkg::REG_STATUS, 8'h12);
		// rate check on an unanswered address byte
		mc = $urandom_range(0, 2);
		code = $urandom_range(0, 5);
		hf = (20 + 2 * code) << mc;
		wr(iec_pkg::REG_RATE, {2'(mc), 6'(code)});
		wr(iec_pkg::REG_CTRL, 8'hF0);
		// the address byte is taken only once the start has pulled the clock low
		@(negedge scl_w);
		wr(iec_pkg::REG_DATA, 8'hFF);
		@(negedge scl_w);
		@(negedge scl_w);
		t0 = $time;
		@(negedge scl_w);
		p = int'(($time - t0) / 50);
		chk_rng("scl_period", 2 * hf, 2 * hf + 4, p[15:0]);
		wait_irq(1'b1);
		rd(iec_pkg::REG_STATUS, 8'hA3, 8'hFF);
		wr(iec_pkg::REG_CTRL, 8'hC0);
		wr(iec_pkg::REG_STATUS, 8'h02);
		wait_irq(1'b0);
		chk_rng("pin_out", 0, 0, {14'h0000, scl_o, sda_o});
		wrap_up();
	end
endmodule
`default_nettype wire
